//--- common/rsws_pkg.sv
// Shared constants and types of the radio sleep/wake scheduler.
// Assumes a 10 MHz system clock and an AXI4-Lite register port with 32-bit data.
// Operation
// - Permanent awake setting keeps the radio operational; sleep is never entered.
// - Timed awake setting stays operational 0 to 255 seconds, then sleeps.
// - Poll wake setting sleeps until the controller polls, then wakes.
// - Timed sleep setting sleeps 0 to 65535 seconds, then wakes.
// - While asleep, no bus access succeeds, programming included.
// - Daily, when time of day equals resync time, the cycle restarts.
// - Time of day held in hours and minutes, only 00:00 to 23:59 accepted.
// - Asleep: radio and I/O power off; watchdog keeps running.
// - Without external power a sleeping radio stays asleep until power returns.
// - Software may load the time of day directly.
`default_nettype none

package rsws_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_AWAKE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SLEEP = 8'h08;
    localparam logic [ADDR_W-1:0] REG_TOD = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_RESYNC = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;

    // Field positions
    localparam int CTRL_AWAKE_TIMED_BIT = 0;
    localparam int CTRL_SLEEP_TIMED_BIT = 1;
    localparam int TOD_MN_LSB = 0;
    localparam int TOD_HR_LSB = 8;
    localparam int TOD_SC_LSB = 16;
    localparam int STAT_AWAKE_BIT = 0;
    localparam int STAT_PWR_BIT = 1;
    localparam int STAT_POLL_BIT = 2;
    localparam int STAT_TIMER_BIT = 3;
    localparam int STAT_RESYNC_BIT = 4;
    localparam int STAT_CNT_LSB = 16;

    // Field widths
    localparam int HR_W = 5;
    localparam int MN_W = 6;
    localparam int AWAKE_W = 8;
    localparam int SLEEP_W = 16;

    // Time-of-day limits
    localparam logic [HR_W-1:0] HR_MAX = 5'h17;
    localparam logic [MN_W-1:0] MN_MAX = 6'h3b;
    localparam logic [MN_W-1:0] SC_MAX = 6'h3b;

    // Reset values
    localparam logic [HR_W-1:0] RST_RS_HR = 5'h01;
    localparam logic [MN_W-1:0] RST_RS_MN = 6'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SEC_NS = 1000000000;
    localparam int unsigned TICK_CYC = SEC_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 24;

    typedef enum logic {
        ST_AWAKE,
        ST_SLEEP
    } rsws_phase_t;

endpackage

`default_nettype wire

//--- hw/rsws_tick.sv
// One-second time base for the scheduler.
// Assumes a free-running clock; the period in cycles is a parameter.
`default_nettype none

module rsws_tick #(
    parameter int unsigned CYCLES = rsws_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // One-cycle pulse per second
    output logic tick
);
    import rsws_pkg::*;

    localparam logic [TICK_W-1:0] LAST = TICK_W'(CYCLES - 1);

    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic tick;
    } rsws_tick_t;

    rsws_tick_t s_q;
    rsws_tick_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= LAST) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

`default_nettype wire

//--- hw/rsws_sched.sv
// Sleep/wake scheduler with time-of-day clock and AXI4-Lite registers.
// Assumes host_poll and ext_pwr_ok are synchronous to clk.
`default_nettype none

module rsws_sched #(
    parameter int unsigned TICK_CYCLES = rsws_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Controller poll and supply state
    input wire logic host_poll,
    input wire logic ext_pwr_ok,
    // Power and link control
    output logic awake,
    output logic radio_pwr_en,
    output logic io_pwr_en,
    output logic comm_en,
    output logic wdog_run,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rsws_pkg::ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [rsws_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [rsws_pkg::ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [rsws_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import rsws_pkg::*;

    typedef struct packed {
        rsws_phase_t st;
        logic awake_timed;
        logic sleep_timed;
        logic [AWAKE_W-1:0] awake_secs;
        logic [SLEEP_W-1:0] sleep_secs;
        logic [SLEEP_W-1:0] cnt;
        logic [HR_W-1:0] hr;
        logic [MN_W-1:0] mn;
        logic [MN_W-1:0] sc;
        logic [HR_W-1:0] rs_hr;
        logic [MN_W-1:0] rs_mn;
        logic woke_poll;
        logic woke_timer;
        logic woke_resync;
        logic aw_have;
        logic w_have;
        logic [ADDR_W-1:0] aw_addr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
        logic awake;
        logic radio_pwr;
        logic io_pwr;
        logic comm;
        logic wdog;
    } rsws_state_t;

    rsws_state_t s_q;
    rsws_state_t s_d;
    logic tick;

    rsws_tick #(
        .CYCLES(TICK_CYCLES)
    ) rsws_tick_inst (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    // Readback of one register: bit 32 flags a mapped address
    function automatic logic [DATA_W:0] reg_rd(input rsws_state_t s, input logic [ADDR_W-1:0] a,
                                               input logic pwr);
        logic [DATA_W-1:0] v;
        logic hit;
        v = '0;
        hit = 1'b1;
        unique case ({a[ADDR_W-1:2], 2'b00})
            REG_CTRL: begin
                v[CTRL_AWAKE_TIMED_BIT] = s.awake_timed;
                v[CTRL_SLEEP_TIMED_BIT] = s.sleep_timed;
            end
            REG_AWAKE: begin
                v[AWAKE_W-1:0] = s.awake_secs;
            end
            REG_SLEEP: begin
                v[SLEEP_W-1:0] = s.sleep_secs;
            end
            REG_TOD: begin
                v[TOD_MN_LSB +: MN_W] = s.mn;
                v[TOD_HR_LSB +: HR_W] = s.hr;
                v[TOD_SC_LSB +: MN_W] = s.sc;
            end
            REG_RESYNC: begin
                v[TOD_MN_LSB +: MN_W] = s.rs_mn;
                v[TOD_HR_LSB +: HR_W] = s.rs_hr;
            end
            REG_STATUS: begin
                v[STAT_AWAKE_BIT] = s.awake;
                v[STAT_PWR_BIT] = pwr;
                v[STAT_POLL_BIT] = s.woke_poll;
                v[STAT_TIMER_BIT] = s.woke_timer;
                v[STAT_RESYNC_BIT] = s.woke_resync;
                v[STAT_CNT_LSB +: SLEEP_W] = s.cnt;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return {hit, v};
    endfunction

    // Byte-lane merge of write data over the current register contents
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] wd,
                                                input logic [3:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [DATA_W:0] rd;
        logic [DATA_W-1:0] wv;
        logic [HR_W-1:0] whr;
        logic [MN_W-1:0] wmn;
        logic minute_roll;
        logic resync_hit;
        logic can_wake;
        logic resync_set;
        rd = '0;
        wv = '0;
        whr = '0;
        wmn = '0;
        minute_roll = 1'b0;
        resync_hit = 1'b0;
        can_wake = 1'b0;
        resync_set = 1'b0;
        s_d = s_q;

        // Time of day, advanced once a second
        if (tick) begin
            if (s_q.sc >= SC_MAX) begin
                s_d.sc = '0;
                minute_roll = 1'b1;
                if (s_q.mn >= MN_MAX) begin
                    s_d.mn = '0;
                    if (s_q.hr >= HR_MAX) begin
                        s_d.hr = '0;
                    end else begin
                        s_d.hr = s_q.hr + 1'b1;
                    end
                end else begin
                    s_d.mn = s_q.mn + 1'b1;
                end
            end else begin
                s_d.sc = s_q.sc + 1'b1;
            end
        end
        resync_hit = minute_roll && (s_d.hr == s_q.rs_hr) && (s_d.mn == s_q.rs_mn);

        // Phase sequencing
        unique case (s_q.st)
            ST_AWAKE: begin
                // Permanent mode never leaves this state
                if (s_q.awake_timed) begin
                    if (s_q.cnt == '0) begin
                        s_d.st = ST_SLEEP;
                        s_d.cnt = s_q.sleep_secs;
                    end else if (tick) begin
                        s_d.cnt = s_q.cnt - 1'b1;
                    end
                end
            end
            ST_SLEEP: begin
                // A wake also needs external power; the battery alone cannot run the radio
                if (s_q.sleep_timed) begin
                    can_wake = (s_q.cnt == '0) && ext_pwr_ok;
                end else begin
                    can_wake = host_poll && ext_pwr_ok;
                end
                if (can_wake) begin
                    s_d.st = ST_AWAKE;
                    s_d.cnt = {{(SLEEP_W-AWAKE_W){1'b0}}, s_q.awake_secs};
                    s_d.woke_poll = s_q.woke_poll | ~s_q.sleep_timed;
                    s_d.woke_timer = s_q.woke_timer | s_q.sleep_timed;
                end else if (tick && s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
        endcase

        // Daily restart of the cycle at its operational start
        if (resync_hit && s_q.awake_timed && ext_pwr_ok) begin
            s_d.st = ST_AWAKE;
            s_d.cnt = {{(SLEEP_W-AWAKE_W){1'b0}}, s_q.awake_secs};
            s_d.woke_resync = 1'b1;
            resync_set = 1'b1;
        end

        // Write address and data, taken in either order
        if (s_q.awready && s_axi_awvalid) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
            s_d.awready = 1'b0;
        end
        if (s_q.wready && s_axi_wvalid) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
            s_d.wready = 1'b0;
        end

        // Write execution, placed after the clock so a load wins over the tick
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            rd = reg_rd(s_q, s_q.aw_addr, ext_pwr_ok);
            wv = merge(rd[DATA_W-1:0], s_q.wdata, s_q.wstrb);
            whr = wv[TOD_HR_LSB +: HR_W];
            wmn = wv[TOD_MN_LSB +: MN_W];
            if (s_q.st != ST_AWAKE) begin
                s_d.bresp = RESP_SLVERR;
            end else begin
                unique case ({s_q.aw_addr[ADDR_W-1:2], 2'b00})
                    REG_CTRL: begin
                        s_d.awake_timed = wv[CTRL_AWAKE_TIMED_BIT];
                        s_d.sleep_timed = wv[CTRL_SLEEP_TIMED_BIT];
                        // Entering timed mode starts a fresh awake period
                        if (!s_q.awake_timed && wv[CTRL_AWAKE_TIMED_BIT]) begin
                            s_d.cnt = {{(SLEEP_W-AWAKE_W){1'b0}}, s_q.awake_secs};
                        end
                    end
                    REG_AWAKE: begin
                        s_d.awake_secs = wv[AWAKE_W-1:0];
                    end
                    REG_SLEEP: begin
                        s_d.sleep_secs = wv[SLEEP_W-1:0];
                    end
                    REG_TOD: begin
                        if (whr <= HR_MAX && wmn <= MN_MAX) begin
                            s_d.hr = whr;
                            s_d.mn = wmn;
                            s_d.sc = '0;
                        end else begin
                            s_d.bresp = RESP_SLVERR;
                        end
                    end
                    REG_RESYNC: begin
                        if (whr <= HR_MAX && wmn <= MN_MAX) begin
                            s_d.rs_hr = whr;
                            s_d.rs_mn = wmn;
                        end else begin
                            s_d.bresp = RESP_SLVERR;
                        end
                    end
                    REG_STATUS: begin
                        // Write one to clear; a wake in the same cycle keeps its flag
                        s_d.woke_poll = s_d.woke_poll &
                            ~(s_q.woke_poll & s_q.wdata[STAT_POLL_BIT] & s_q.wstrb[0]);
                        s_d.woke_timer = s_d.woke_timer &
                            ~(s_q.woke_timer & s_q.wdata[STAT_TIMER_BIT] & s_q.wstrb[0]);
                        s_d.woke_resync = (s_q.woke_resync &
                            ~(s_q.wdata[STAT_RESYNC_BIT] & s_q.wstrb[0])) | resync_set;
                    end
                    default: begin
                        s_d.bresp = RESP_SLVERR;
                    end
                endcase
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end

        // Read channel, answered one cycle after the address is taken
        if (s_q.arready && s_axi_arvalid) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            rd = reg_rd(s_q, s_axi_araddr, ext_pwr_ok);
            if (s_q.st != ST_AWAKE) begin
                s_d.rdata = '0;
                s_d.rresp = RESP_SLVERR;
            end else begin
                s_d.rdata = rd[DATA_W-1:0];
                s_d.rresp = rd[DATA_W] ? RESP_OKAY : RESP_SLVERR;
            end
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        // Power and link gating follow the phase
        s_d.awake = (s_d.st == ST_AWAKE);
        s_d.radio_pwr = s_d.awake;
        s_d.io_pwr = s_d.awake;
        s_d.comm = s_d.awake;
        s_d.wdog = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ST_AWAKE;
            s_q.rs_hr <= RST_RS_HR;
            s_q.rs_mn <= RST_RS_MN;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
            s_q.awake <= 1'b1;
            s_q.radio_pwr <= 1'b1;
            s_q.io_pwr <= 1'b1;
            s_q.comm <= 1'b1;
            s_q.wdog <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign awake = s_q.awake;
    assign radio_pwr_en = s_q.radio_pwr;
    assign io_pwr_en = s_q.io_pwr;
    assign comm_en = s_q.comm;
    assign wdog_run = s_q.wdog;
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

endmodule

`default_nettype wire

//--- tb/rsws_plc_model.sv
// Behavioural model of the attached controller that polls the radio.
// Assumes the bench asks for a poll by holding poll_req high.
`default_nettype none

module rsws_plc_model (
    // Clock
    input wire logic clk,
    // Bench command
    input wire logic poll_req,
    // Poll line to the radio
    output logic host_poll
);
    timeunit 1ns;
    timeprecision 1ns;

    // Registered so the poll changes just after an edge, like real synchronous logic
    initial host_poll = 1'b0;
    always @(posedge clk) host_poll <= poll_req;
endmodule

`default_nettype wire

//--- tb/rsws_sched_props.sv
// Port-level checker for the sleep/wake scheduler.
// Assumes one clock domain with an asynchronous active-low reset.
`default_nettype none

module rsws_sched_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Supply and phase
    input wire logic ext_pwr_ok,
    input wire logic awake,
    input wire logic radio_pwr_en,
    input wire logic io_pwr_en,
    input wire logic comm_en,
    input wire logic wdog_run,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [rsws_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    timeunit 1ns;
    timeprecision 1ns;
    import rsws_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_up;
        ##1 !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    property p_wr_lat; s_wr_take |-> s_b_up; endproperty
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_pwr; radio_pwr_en == awake && io_pwr_en == awake; endproperty
    property p_comm; comm_en == awake; endproperty
    property p_wdog; wdog_run; endproperty
    property p_nopwr; !awake && !ext_pwr_ok |=> !awake; endproperty
    property p_wr_asleep;
        $rose(s_axi_bvalid) && !$past(awake) |-> s_axi_bresp == RESP_SLVERR;
    endproperty
    property p_rd_asleep;
        $rose(s_axi_rvalid) && !$past(awake) |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
    endproperty

    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_pwr: assert property (p_pwr) else $error("power enables differ from phase");
    a_comm: assert property (p_comm) else $error("comm enable differs from phase");
    a_wdog: assert property (p_wdog) else $error("watchdog stopped");
    a_nopwr: assert property (p_nopwr) else $error("woke without power");
    a_wr_asleep: assert property (p_wr_asleep) else $error("write accepted asleep");
    a_rd_asleep: assert property (p_rd_asleep) else $error("read accepted asleep");
endmodule

bind rsws_sched rsws_sched_props rsws_sched_props_inst (.clk, .rst_n, .ext_pwr_ok, .awake,
    .radio_pwr_en, .io_pwr_en, .comm_en, .wdog_run, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp);

`default_nettype wire

//--- tb/rsws_sched_tb.sv
// Self-checking bench for the sleep/wake scheduler.
// Assumes a ten-cycle second so whole phases fit in a short run.
`default_nettype none

module rsws_sched_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rsws_pkg::*;

    localparam int TK = 10;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rsws_rexp_t;
    logic clk = 1'b0, rst_n = 1'b0, ext_pwr_ok = 1'b1, poll_req = 1'b0, host_poll;
    logic awake, radio_pwr_en, io_pwr_en, comm_en, wdog_run;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] wq[$];
    rsws_rexp_t rq[$];
    int n_mismatch = 0, n_checks = 0, cyc = 0, t0;
    integer seed = 32'h94c10b87;

    rsws_sched #(.TICK_CYCLES(TK)) rsws_sched_inst (.clk, .rst_n, .host_poll, .ext_pwr_ok,
        .awake, .radio_pwr_en, .io_pwr_en, .comm_en, .wdog_run, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    rsws_plc_model rsws_plc_model_inst (.clk, .poll_req, .host_poll);

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic bad(input string s);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, s);
    endtask
    task automatic give_verdict;
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp_b(input logic [1:0] e);
        n_checks++;
        if (s_axi_bresp !== e) bad("write response");
    endtask
    task automatic cmp_r(input rsws_rexp_t e);
        n_checks++;
        if ((s_axi_rdata & e.m) !== e.d || s_axi_rresp !== e.r) bad("read data or response");
    endtask
    task automatic cmp_lvl(input logic e, input logic g);
        n_checks++;
        if (g !== e) bad("phase output");
    endtask
    task automatic cmp_rng(input int n, input int lo, input int hi);
        n_checks++;
        if (n < lo || n > hi) bad("phase duration");
    endtask

    // Each result is matched against the oldest note of its kind
    always @(posedge clk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready) cmp_b(wq.pop_front());
        if (s_axi_rvalid === 1'b1 && s_axi_rready) cmp_r(rq.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                      input logic [3:0] s = 4'hf);
        logic aw_t, w_t;
        aw_t = 0;
        w_t = 0;
        wq.push_back(r);
        @(posedge clk);
        s_axi_awvalid <= 1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1;
        while (!(aw_t === 1'b1 && w_t === 1'b1)) begin
            @(posedge clk);
            aw_t = aw_t | (s_axi_awready & s_axi_awvalid);
            w_t = w_t | (s_axi_wready & s_axi_wvalid);
            if (aw_t) s_axi_awvalid <= 0;
            if (w_t) s_axi_wvalid <= 0;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        rq.push_back(rsws_rexp_t'{d, m, r});
        @(posedge clk);
        s_axi_arvalid <= 1;
        s_axi_araddr <= a;
        s_axi_rready <= 1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
    endtask
    task automatic wait_ph(input logic v, input int lim);
        int n;
        n = 0;
        while (awake !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        rd(REG_CTRL, 32'h0, 32'hffffffff, RESP_OKAY);
        rd(REG_RESYNC, 32'h0100, 32'h1fff, RESP_OKAY);
        rd(REG_STATUS, 32'h3, 32'h3, RESP_OKAY);
        rd(8'h18, 32'h0, 32'hffffffff, RESP_SLVERR);
        wr(REG_TOD, 32'h173b, RESP_OKAY);
        t0 = cyc;
        wr(REG_TOD, 32'h183b, RESP_SLVERR);
        wr(REG_TOD, 32'h173c, RESP_SLVERR);
        rd(REG_TOD, 32'h173b, 32'h1fff, RESP_OKAY);
        repeat (60 * TK + 5 - (cyc - t0)) @(posedge clk);
        rd(REG_TOD, 32'h0, 32'h1fff, RESP_OKAY);
        cmp_lvl(1, awake);
        rv = $random(seed);
        wr(REG_AWAKE, rv, RESP_OKAY, 4'h1);
        rd(REG_AWAKE, {24'h0, rv[7:0]}, 32'hff, RESP_OKAY);
        wr(REG_AWAKE, 32'h3, RESP_OKAY);
        wr(REG_SLEEP, 32'h4, RESP_OKAY);
        wr(REG_CTRL, 32'h3, RESP_OKAY);
        t0 = cyc;
        wait_ph(0, 4 * TK);
        cmp_rng(cyc - t0, 2 * TK - 3, 3 * TK + 3);
        t0 = cyc;
        cmp_lvl(0, radio_pwr_en);
        cmp_lvl(0, io_pwr_en);
        rd(REG_AWAKE, 32'h0, 32'hffffffff, RESP_SLVERR);
        wr(REG_AWAKE, 32'h9, RESP_SLVERR);
        wait_ph(1, 5 * TK);
        cmp_rng(cyc - t0, 3 * TK - 3, 4 * TK + 3);
        rd(REG_AWAKE, 32'h3, 32'hff, RESP_OKAY);
        // Supply lost while asleep: the sleep timer may expire but wake must wait
        wait_ph(0, 4 * TK);
        ext_pwr_ok <= 0;
        repeat (6 * TK) @(posedge clk);
        cmp_lvl(0, awake);
        ext_pwr_ok <= 1;
        t0 = cyc;
        wait_ph(1, 2 * TK);
        cmp_rng(cyc - t0, 0, 3);
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        wait_ph(0, 4 * TK);
        repeat (5 * TK) @(posedge clk);
        cmp_lvl(0, awake);
        ext_pwr_ok <= 0;
        poll_req <= 1;
        repeat (4) @(posedge clk);
        cmp_lvl(0, awake);
        ext_pwr_ok <= 1;
        t0 = cyc;
        wait_ph(1, 5);
        cmp_rng(cyc - t0, 1, 3);
        poll_req <= 0;
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        wr(REG_SLEEP, 32'hffff, RESP_OKAY);
        wr(REG_RESYNC, 32'h0500, RESP_OKAY);
        wr(REG_TOD, 32'h043b, RESP_OKAY);
        wr(REG_CTRL, 32'h3, RESP_OKAY);
        wait_ph(0, 4 * TK);
        t0 = cyc;
        wait_ph(1, 62 * TK);
        cmp_rng(cyc - t0, 50 * TK, 60 * TK);
        rd(REG_STATUS, 32'h11, 32'h11, RESP_OKAY);
        wr(REG_STATUS, 32'h10, RESP_OKAY, 4'h1);
        rd(REG_STATUS, 32'h01, 32'h11, RESP_OKAY);
        give_verdict;
    end

    initial begin
        repeat (4000) @(posedge clk);
        bad("watchdog expired");
        give_verdict;
    end
endmodule

`default_nettype wire
